// ---- src/frs_regs_top.sv ----
// GPIO2 fast-role-swap, sink transmit and source swap register bank
`timescale 1ns/10ps
// How it works
// R01: Output enabled, swap function off: GPIO2 drives the stored output value.
// R02: Sink swap mode: pin driven high, forced low once VBUS disconnect seen.
// R03: Swap function off: input enable gates the GPIO2 input into status.
// R04: Source swap mode: GPIO2 falling edge starts swap signaling promptly.
// R05: Output enable low leaves GPIO2 undriven; high drives it.
// R06: Status bit 1 shows GPIO2 level, bit 0 GPIO1, each when enabled.
// R07: Toggle select code picks source and sink toggle windows.
// R08: Sink write arms transmit, sent when advertisement moves 1.5 A to 3.0 A.
// R09: Hard reset, cable reset and carrier mode are sent once, never retried.
// R10: Software must not write sink transmit while acting as source.
// R11: After first message, software watches CC status for advertisement changes.
// R12: Bit 6 disables sink transmit; reset value 0x40 leaves it disabled.
// R13: Retry count sets automatic resends of a failed message, zero to three.
// R14: Packet type picks SOP kinds, hard reset, cable reset or carrier mode.
// R15: Automatic sink gate turns on after 0, 150, 300 or 600 us.
// R16: Zero delay gates with initiate; nonzero delay counts from signaling done.
// R17: Manual sink gate mode never turns the gate on by itself.
// R18: Writing 1 to initiate starts the swap; the bit clears by itself.
// R19: Sticky write-one-to-clear flags for swap sent by GPIO and swap received.
// R20: Reserved bits read zero and ignore writes.
module frs_regs_top
    import frs_pkg::*;
#(
    parameter int GATE_DLY1_CYC = FRS_GATE_DLY1_CYC,
    parameter int GATE_DLY2_CYC = FRS_GATE_DLY2_CYC,
    parameter int GATE_DLY3_CYC = FRS_GATE_DLY3_CYC,
    parameter int BIST_CYC = FRS_BIST_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic gpio1_input_enable,
    input wire logic gpio1_pin_in,
    input wire logic gpio2_pin_in,
    output logic gpio2_pin_out,
    output logic gpio2_pin_oe,
    input wire logic vbus_disconnect,
    input wire logic role_is_sink,
    input wire logic rp_adv_1p5a,
    input wire logic rp_adv_3p0a,
    output logic tx_start,
    output logic [2:0] tx_packet_type,
    input wire logic tx_done,
    input wire logic tx_failed,
    output logic bist_active,
    output logic frs_signal_start,
    input wire logic frs_signal_done,
    input wire logic frs_request_rx,
    output logic sink_gate_en,
    output logic [6:0] drp_src_min_ms,
    output logic [6:0] drp_snk_min_ms
);
    localparam int CW = 18;

    logic [1:0] pins_sync;
    logic [7:0] gpio2_config_q, gpio2_config_d, drp_q, drp_d, snk_tx_q, snk_tx_d;
    logic [7:0] src_q, src_d, evt_q, evt_d, stat_q, stat_d, rdata_d;
    logic force_low_q, force_low_d, g2_prev_q, pin_out_d, init_q, init_d;
    logic wr_g2, wr_drp, wr_snk, wr_src, wr_evt;
    logic g2_oe, g2_ie, g2_val, g2_fn, gpio_edge, frs_go;
    logic rp_1p5_q, rp_step;
    logic [1:0] gate_dly;
    logic gate_manual;

    // Pins come from outside the clock domain
    frs_sync #(.W(2)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .din({gpio2_pin_in, gpio1_pin_in}),
        .dout(pins_sync)
    );

    // Register write decode
    always_comb begin
        wr_g2 = 1'b0;
        wr_drp = 1'b0;
        wr_snk = 1'b0;
        wr_src = 1'b0;
        wr_evt = 1'b0;
        if (reg_wr && reg_addr == FRS_ADDR_GPIO2_CONFIG) begin
            wr_g2 = 1'b1;
        end else if (reg_wr && reg_addr == FRS_ADDR_DRP_TOGGLE) begin
            wr_drp = 1'b1;
        end else if (reg_wr && reg_addr == FRS_ADDR_SNK_TX) begin
            wr_snk = 1'b1;
        end else if (reg_wr && reg_addr == FRS_ADDR_SRC_FRS) begin
            wr_src = 1'b1;
        end else if (reg_wr && reg_addr == FRS_ADDR_EVENTS) begin
            wr_evt = 1'b1;
        end
    end

    assign g2_oe = gpio2_config_q[FRS_G2_OE_BIT];
    assign g2_ie = gpio2_config_q[FRS_G2_IE_BIT];
    assign g2_val = gpio2_config_q[FRS_G2_VAL_BIT];
    assign g2_fn = gpio2_config_q[FRS_G2_FN_BIT];
    // Gate mode follows the value being written, so a write that sets initiate obeys its own delay and mode
    assign gate_manual = src_d[FRS_SRC_MAN_BIT];
    assign gate_dly = src_d[FRS_SRC_DLY_LSB +: 2];
    // Falling edge seen only in source swap mode
    assign gpio_edge = g2_fn && !g2_oe && g2_ie && g2_prev_q && !pins_sync[1]; // R04
    assign frs_go = (wr_src && reg_wdata[FRS_SRC_INIT_BIT]) || gpio_edge; // R18
    assign rp_step = rp_1p5_q && rp_adv_3p0a; // R08

    // Register next values, pin drive, status and read data
    always_comb begin
        gpio2_config_d = wr_g2 ? (reg_wdata & FRS_MASK_GPIO2_CONFIG) : gpio2_config_q; // R20
        drp_d = wr_drp ? (reg_wdata & FRS_MASK_DRP_TOGGLE) : drp_q;
        snk_tx_d = wr_snk ? (reg_wdata & FRS_MASK_SNK_TX) : snk_tx_q;
        src_d = wr_src ? (reg_wdata & FRS_MASK_SRC_FRS) : src_q;
        init_d = wr_src && reg_wdata[FRS_SRC_INIT_BIT]; // R18
        // Set wins over a same-cycle write-one clear
        evt_d = evt_q;
        if (wr_evt) begin
            evt_d = evt_q & ~(reg_wdata & FRS_MASK_EVENTS);
        end
        if (gpio_edge) begin
            evt_d[FRS_EVT_TX_BIT] = 1'b1; // R19
        end
        if (frs_request_rx) begin
            evt_d[FRS_EVT_RX_BIT] = 1'b1; // R19
        end
        // Forced-low latch holds until software rewrites the pin config
        force_low_d = force_low_q && !wr_g2;
        if (g2_fn && g2_oe && g2_val && vbus_disconnect) begin
            force_low_d = 1'b1; // R02
        end
        pin_out_d = g2_fn ? (g2_val && !force_low_q) : g2_val; // R01 R02
        stat_d = 8'h00;
        stat_d[FRS_STAT_G2_BIT] = pins_sync[1] && g2_ie; // R03 R06
        stat_d[FRS_STAT_G1_BIT] = pins_sync[0] && gpio1_input_enable; // R06
        rdata_d = reg_rdata;
        if (reg_rd) begin
            if (reg_addr == FRS_ADDR_GPIO2_CONFIG) begin
                rdata_d = gpio2_config_q;
            end else if (reg_addr == FRS_ADDR_GPIO_STAT) begin
                rdata_d = stat_q & FRS_MASK_GPIO_STAT;
            end else if (reg_addr == FRS_ADDR_DRP_TOGGLE) begin
                rdata_d = drp_q;
            end else if (reg_addr == FRS_ADDR_SNK_TX) begin
                rdata_d = snk_tx_q;
            end else if (reg_addr == FRS_ADDR_SRC_FRS) begin
                rdata_d = src_q | {7'h00, init_q};
            end else if (reg_addr == FRS_ADDR_EVENTS) begin
                rdata_d = evt_q;
            end else begin
                rdata_d = 8'h00; // R20
            end
        end
    end

    // Register bank, pin and status flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpio2_config_q <= FRS_RST_GPIO2_CONFIG;
            drp_q <= FRS_RST_DRP_TOGGLE;
            snk_tx_q <= FRS_RST_SNK_TX; // R12
            src_q <= FRS_RST_SRC_FRS;
            evt_q <= FRS_RST_EVENTS;
            init_q <= 1'b0;
            force_low_q <= 1'b0;
            g2_prev_q <= 1'b0;
            rp_1p5_q <= 1'b0;
            stat_q <= 8'h00;
            reg_rdata <= 8'h00;
            gpio2_pin_out <= 1'b0;
            gpio2_pin_oe <= 1'b0;
            frs_signal_start <= 1'b0;
            drp_src_min_ms <= FRS_DRP_SRC_MIN_MS[0];
            drp_snk_min_ms <= FRS_DRP_SNK_MIN_MS[0];
        end else begin
            gpio2_config_q <= gpio2_config_d;
            drp_q <= drp_d;
            snk_tx_q <= snk_tx_d;
            src_q <= src_d;
            evt_q <= evt_d;
            init_q <= init_d;
            force_low_q <= force_low_d;
            g2_prev_q <= pins_sync[1];
            rp_1p5_q <= rp_adv_1p5a;
            stat_q <= stat_d;
            reg_rdata <= rdata_d;
            gpio2_pin_out <= pin_out_d;
            gpio2_pin_oe <= g2_oe; // R05
            frs_signal_start <= frs_go; // R04
            drp_src_min_ms <= FRS_DRP_SRC_MIN_MS[drp_q[1:0]]; // R07
            drp_snk_min_ms <= FRS_DRP_SNK_MIN_MS[drp_q[1:0]]; // R07
        end
    end

    // Sink gate: immediate, delayed after signaling done, or left to software
    logic gate_q, gate_d, gate_wait_q, gate_wait_d;
    logic [CW-1:0] gate_cnt_q, gate_cnt_d, gate_load;

    always_comb begin
        case (gate_dly)
            2'h1: gate_load = CW'(GATE_DLY1_CYC - 1);
            2'h2: gate_load = CW'(GATE_DLY2_CYC - 1);
            default: gate_load = CW'(GATE_DLY3_CYC - 1);
        endcase
        gate_d = gate_q;
        gate_wait_d = gate_wait_q;
        gate_cnt_d = gate_cnt_q;
        // A plain write to the swap register withdraws the gate
        if (wr_src && !reg_wdata[FRS_SRC_INIT_BIT]) begin
            gate_d = 1'b0;
            gate_wait_d = 1'b0;
        end
        if (gate_manual) begin
            gate_wait_d = 1'b0; // R17
        end else if (frs_go && gate_dly == 2'h0) begin
            gate_d = 1'b1; // R16
        end else if (frs_signal_done && gate_dly != 2'h0) begin
            gate_wait_d = 1'b1; // R15 R16
            gate_cnt_d = gate_load;
        end else if (gate_wait_q) begin
            if (gate_cnt_q == '0) begin
                gate_d = 1'b1; // R15
                gate_wait_d = 1'b0;
            end else begin
                gate_cnt_d = gate_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_q <= 1'b0;
            gate_wait_q <= 1'b0;
            gate_cnt_q <= '0;
        end else begin
            gate_q <= gate_d;
            gate_wait_q <= gate_wait_d;
            gate_cnt_q <= gate_cnt_d;
        end
    end
    assign sink_gate_en = gate_q;

    // Sink transmit sequencer
    frs_tx_state_t tx_st_q, tx_st_d;
    logic [1:0] tries_q, tries_d;
    logic [CW-1:0] bist_cnt_q, bist_cnt_d;
    logic tx_start_d, once_only;
    logic [2:0] pkt;

    assign pkt = snk_tx_q[FRS_TYPE_LSB +: 3];
    // Reset and carrier signaling cannot be retried
    assign once_only = pkt == FRS_PKT_HARD_RST || pkt == FRS_PKT_CABLE_RST || pkt == FRS_PKT_BIST_CM2; // R09

    always_comb begin
        tx_st_d = tx_st_q;
        tries_d = tries_q;
        bist_cnt_d = bist_cnt_q;
        tx_start_d = 1'b0;
        case (tx_st_q)
            FRS_TX_IDLE: begin
                // Writes while source are not honoured
                if (wr_snk && role_is_sink && !reg_wdata[FRS_SNK_DIS_BIT]) begin // R08 R12
                    tx_st_d = FRS_TX_WAIT_RP;
                    tries_d = 2'h0;
                end
            end
            FRS_TX_WAIT_RP: begin
                if (snk_tx_q[FRS_SNK_DIS_BIT] || !role_is_sink) begin
                    tx_st_d = FRS_TX_IDLE; // R12
                end else if (rp_step) begin
                    tx_st_d = FRS_TX_SEND; // R08
                end
            end
            FRS_TX_SEND: begin
                tx_start_d = 1'b1;
                if (pkt == FRS_PKT_BIST_CM2) begin
                    tx_st_d = FRS_TX_BIST; // R14
                    bist_cnt_d = CW'(BIST_CYC - 1);
                end else begin
                    tx_st_d = FRS_TX_WAIT_DONE;
                end
            end
            FRS_TX_WAIT_DONE: begin
                if (tx_done) begin
                    if (tx_failed && !once_only && tries_q < snk_tx_q[FRS_RETRY_LSB +: 2]) begin // R13 R09
                        tries_d = tries_q + 2'h1;
                        tx_st_d = FRS_TX_SEND;
                    end else begin
                        tx_st_d = FRS_TX_IDLE;
                    end
                end
            end
            FRS_TX_BIST: begin
                if (bist_cnt_q == '0) begin
                    tx_st_d = FRS_TX_IDLE; // R14
                end else begin
                    bist_cnt_d = bist_cnt_q - 1'b1;
                end
            end
            default: tx_st_d = FRS_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_st_q <= FRS_TX_IDLE;
            tries_q <= 2'h0;
            bist_cnt_q <= '0;
            tx_start <= 1'b0;
            tx_packet_type <= 3'h0;
            bist_active <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            tries_q <= tries_d;
            bist_cnt_q <= bist_cnt_d;
            tx_start <= tx_start_d;
            tx_packet_type <= pkt; // R14
            bist_active <= tx_st_d == FRS_TX_BIST;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_gpio_drive_level: assert property (g2_oe && !g2_fn |=> gpio2_pin_out == $past(g2_val)) // R01
        else $error("GPIO2 level differs from stored value");
    a_sink_force_low: assert property (force_low_q && g2_fn |=> !gpio2_pin_out) // R02
        else $error("GPIO2 not forced low after disconnect");
    a_stat_gated: assert property (!g2_ie |=> !stat_q[FRS_STAT_G2_BIT]) // R03 R06
        else $error("GPIO2 status shown while input disabled");
    a_edge_starts_frs: assert property (gpio_edge |=> frs_signal_start && evt_q[FRS_EVT_TX_BIT]) // R04 R19
        else $error("Swap not started on GPIO2 falling edge");
    a_pin_hiz: assert property (##1 gpio2_pin_oe == $past(g2_oe)) // R05
        else $error("GPIO2 driver enable wrong");
    a_drp_window: assert property (drp_q == 8'h03 |=> drp_src_min_ms == 7'h1E && drp_snk_min_ms == 7'h14) // R07
        else $error("Toggle window wrong for code 3");
    a_tx_on_rp: assert property (tx_st_q == FRS_TX_WAIT_RP && rp_step && !snk_tx_q[FRS_SNK_DIS_BIT]
        && role_is_sink |=> ##1 tx_start) // R08
        else $error("Transmit not started on advertisement step");
    a_no_retry_reset: assert property (tx_st_q == FRS_TX_WAIT_DONE && tx_done && once_only |=> tx_st_q == FRS_TX_IDLE) // R09
        else $error("Reset signaling retried");
    a_disable_blocks: assert property (tx_st_q == FRS_TX_IDLE && wr_snk && reg_wdata[FRS_SNK_DIS_BIT]
        |=> tx_st_q == FRS_TX_IDLE) // R12
        else $error("Disabled sink transmit armed");
    a_retry_bound: assert property (tx_start |-> tries_q <= snk_tx_q[FRS_RETRY_LSB +: 2]) // R13
        else $error("Too many retries");
    a_gate_delay: assert property (!gate_manual && frs_signal_done && gate_dly == 2'h1 && !frs_go && !wr_src
        |=> gate_cnt_q == CW'(GATE_DLY1_CYC - 1)) // R15
        else $error("Gate delay loaded wrong");
    a_gate_zero: assert property (!gate_manual && gate_dly == 2'h0 && frs_go |=> sink_gate_en) // R16
        else $error("Zero-delay gate not on");
    a_gate_manual: assert property (gate_manual && !wr_src |=> !$rose(sink_gate_en)) // R17
        else $error("Gate turned on in manual mode");
    a_init_clear: assert property (init_q && !wr_src |=> !init_q) // R18
        else $error("Initiate bit did not clear");
    a_rx_flag: assert property (frs_request_rx |=> evt_q[FRS_EVT_RX_BIT]) // R19
        else $error("Receive flag not set");
    a_reserved_zero: assert property (reg_rd && reg_addr == FRS_ADDR_SNK_TX |=> reg_rdata[7] == 1'b0
        && reg_rdata[3] == 1'b0) // R20
        else $error("Reserved bits read non-zero");

    c_sink_tx: cover property (tx_st_q == FRS_TX_WAIT_RP ##[1:50] tx_start);
    c_retry: cover property (tx_done && tx_failed && tx_st_q == FRS_TX_WAIT_DONE ##1 tx_st_q == FRS_TX_SEND);
    c_gpio_frs: cover property (gpio_edge ##1 frs_signal_start);
    c_gate_delay: cover property (gate_wait_q ##1 $rose(sink_gate_en));
endmodule : frs_regs_top

// ---- common/frs_pkg.sv ----
// Constants, register map and types of the fast-role-swap / sink-transmit register bank
package frs_pkg;
    // Register offsets on the host register port
    localparam logic [7:0] FRS_ADDR_GPIO2_CONFIG = 8'hA5;
    localparam logic [7:0] FRS_ADDR_GPIO_STAT = 8'hA6;
    localparam logic [7:0] FRS_ADDR_DRP_TOGGLE = 8'hA7;
    localparam logic [7:0] FRS_ADDR_SNK_TX = 8'hB0;
    localparam logic [7:0] FRS_ADDR_SRC_FRS = 8'hB1;
    localparam logic [7:0] FRS_ADDR_EVENTS = 8'hB3;

    // Reset values
    localparam logic [7:0] FRS_RST_GPIO2_CONFIG = 8'h00;
    localparam logic [7:0] FRS_RST_DRP_TOGGLE = 8'h00;
    localparam logic [7:0] FRS_RST_SNK_TX = 8'h40;
    localparam logic [7:0] FRS_RST_SRC_FRS = 8'h00;
    localparam logic [7:0] FRS_RST_EVENTS = 8'h00;

    // Writable bits of each register, readable bits of the status register; all others read as zero
    localparam logic [7:0] FRS_MASK_GPIO2_CONFIG = 8'h0F;
    localparam logic [7:0] FRS_MASK_GPIO_STAT = 8'h03;
    localparam logic [7:0] FRS_MASK_DRP_TOGGLE = 8'h03;
    localparam logic [7:0] FRS_MASK_SNK_TX = 8'h77;
    localparam logic [7:0] FRS_MASK_SRC_FRS = 8'h0E;
    localparam logic [7:0] FRS_MASK_EVENTS = 8'h03;

    // Field positions
    localparam int FRS_G2_OE_BIT = 0;
    localparam int FRS_G2_IE_BIT = 1;
    localparam int FRS_G2_VAL_BIT = 2;
    localparam int FRS_G2_FN_BIT = 3;
    localparam int FRS_STAT_G1_BIT = 0;
    localparam int FRS_STAT_G2_BIT = 1;
    localparam int FRS_SNK_DIS_BIT = 6;
    localparam int FRS_RETRY_LSB = 4;
    localparam int FRS_TYPE_LSB = 0;
    localparam int FRS_SRC_INIT_BIT = 0;
    localparam int FRS_SRC_MAN_BIT = 1;
    localparam int FRS_SRC_DLY_LSB = 2;
    localparam int FRS_EVT_RX_BIT = 0;
    localparam int FRS_EVT_TX_BIT = 1;

    // Timing: clock rate and sink gate delays
    localparam int FRS_CLK_MHZ = 200;
    localparam int FRS_GATE_DLY1_US = 150;
    localparam int FRS_GATE_DLY2_US = 300;
    localparam int FRS_GATE_DLY3_US = 600;
    localparam int FRS_GATE_DLY1_CYC = FRS_GATE_DLY1_US * FRS_CLK_MHZ;
    localparam int FRS_GATE_DLY2_CYC = FRS_GATE_DLY2_US * FRS_CLK_MHZ;
    localparam int FRS_GATE_DLY3_CYC = FRS_GATE_DLY3_US * FRS_CLK_MHZ;
    // Carrier duration in cycles; plain default, set to the system's figure
    localparam int FRS_BIST_CYC = 4096;

    // Toggle window lower bounds in ms per select code; upper bound is twice this
    localparam logic [6:0] FRS_DRP_SRC_MIN_MS [4] = '{7'h0F, 7'h14, 7'h19, 7'h1E};
    localparam logic [6:0] FRS_DRP_SNK_MIN_MS [4] = '{7'h23, 7'h1E, 7'h19, 7'h14};

    // Transmit packet types
    typedef enum logic [2:0] {
        FRS_PKT_SOP = 3'h0,
        FRS_PKT_SOP1 = 3'h1,
        FRS_PKT_SOP2 = 3'h2,
        FRS_PKT_DBG1 = 3'h3,
        FRS_PKT_DBG2 = 3'h4,
        FRS_PKT_HARD_RST = 3'h5,
        FRS_PKT_CABLE_RST = 3'h6,
        FRS_PKT_BIST_CM2 = 3'h7
    } frs_pkt_t;

    // Sink transmit sequencer states
    typedef enum logic [2:0] {
        FRS_TX_IDLE = 3'b000,
        FRS_TX_WAIT_RP = 3'b001,
        FRS_TX_SEND = 3'b010,
        FRS_TX_WAIT_DONE = 3'b011,
        FRS_TX_BIST = 3'b100
    } frs_tx_state_t;
endpackage : frs_pkg

// ---- src/frs_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module frs_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : frs_sync

// ---- verif/frs_phy_model.sv ----
// Far-side stand-in: PHY and port partner answering transmit and swap-signal starts
`timescale 1ns/10ps
module frs_phy_model #(
    parameter int LAT = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_start,
    input wire logic fail_all,
    input wire logic frs_signal_start,
    output logic tx_done,
    output logic tx_failed,
    output logic frs_signal_done,
    output int n_tx,
    output int n_sw
);
    int tx_cnt_q;
    int sw_cnt_q;
    // Fixed reply latency; every try fails when asked, so retries can be counted
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_cnt_q <= 0;
            sw_cnt_q <= 0;
            n_tx <= 0;
            n_sw <= 0;
            tx_done <= 1'b0;
            tx_failed <= 1'b0;
            frs_signal_done <= 1'b0;
        end else begin
            tx_cnt_q <= tx_start ? LAT : (tx_cnt_q > 0 ? tx_cnt_q - 1 : 0);
            sw_cnt_q <= frs_signal_start ? LAT : (sw_cnt_q > 0 ? sw_cnt_q - 1 : 0);
            n_tx <= n_tx + int'(tx_start);
            n_sw <= n_sw + int'(frs_signal_start);
            tx_done <= (tx_cnt_q == 1);
            tx_failed <= (tx_cnt_q == 1) && fail_all;
            frs_signal_done <= (sw_cnt_q == 1);
        end
    end
endmodule : frs_phy_model

// ---- verif/frs_regs_top_bench.sv ----
// Self-checking bench of the swap and sink-transmit register bank
`timescale 1ns/10ps
module frs_regs_top_bench
    import frs_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, gpio1_input_enable, gpio1_pin_in, gpio2_pin_in, vbus_disconnect;
    logic role_is_sink, rp_adv_1p5a, rp_adv_3p0a, frs_request_rx, fail_all;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic gpio2_pin_out, gpio2_pin_oe, tx_start, tx_done, tx_failed, bist_active;
    logic frs_signal_start, frs_signal_done, sink_gate_en;
    logic [2:0] tx_packet_type;
    logic [6:0] drp_src_min_ms, drp_snk_min_ms;
    int n_tx, n_sw, n_mismatch, n_tests;

    frs_regs_top #(.GATE_DLY1_CYC(8), .GATE_DLY2_CYC(16), .GATE_DLY3_CYC(32), .BIST_CYC(16)) dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio1_input_enable(gpio1_input_enable),
        .gpio1_pin_in(gpio1_pin_in), .gpio2_pin_in(gpio2_pin_in), .gpio2_pin_out(gpio2_pin_out),
        .gpio2_pin_oe(gpio2_pin_oe), .vbus_disconnect(vbus_disconnect), .role_is_sink(role_is_sink),
        .rp_adv_1p5a(rp_adv_1p5a), .rp_adv_3p0a(rp_adv_3p0a), .tx_start(tx_start),
        .tx_packet_type(tx_packet_type), .tx_done(tx_done), .tx_failed(tx_failed),
        .bist_active(bist_active), .frs_signal_start(frs_signal_start),
        .frs_signal_done(frs_signal_done), .frs_request_rx(frs_request_rx), .sink_gate_en(sink_gate_en),
        .drp_src_min_ms(drp_src_min_ms), .drp_snk_min_ms(drp_snk_min_ms));

    frs_phy_model phy_u (.clk(clk), .rst(rst), .tx_start(tx_start), .fail_all(fail_all),
        .frs_signal_start(frs_signal_start), .tx_done(tx_done), .tx_failed(tx_failed),
        .frs_signal_done(frs_signal_done), .n_tx(n_tx), .n_sw(n_sw));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Strobes are dropped and an edge passes, so back-to-back calls never re-raise in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        chk("reg_rdata", reg_rdata, exp);
        reg_rd = 1'b0;
        tick(1);
    endtask : rc

    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic t_reset_and_gpio();
        logic [7:0] addr [7] = '{8'hA5, 8'hA6, 8'hA7, 8'hB0, 8'hB1, 8'hB3, 8'h10};
        logic [7:0] expv [7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
        foreach (addr[i]) rc(addr[i], expv[i]);
        wr(8'hA5, 8'h05);
        chk("pin_out", {7'h0, gpio2_pin_out}, 8'h01);
        chk("pin_oe", {7'h0, gpio2_pin_oe}, 8'h01);
        wr(8'hA5, 8'hF1);
        chk("pin_out", {7'h0, gpio2_pin_out}, 8'h00);
        rc(8'hA5, 8'h01);
        wr(8'hA5, 8'h00);
        chk("pin_oe", {7'h0, gpio2_pin_oe}, 8'h00);
        wr(8'hA5, 8'h02);
        gpio2_pin_in = 1'b1;
        gpio1_input_enable = 1'b1;
        gpio1_pin_in = 1'b1;
        tick(4);
        rc(8'hA6, 8'h03);
        wr(8'hA6, 8'hFF);
        gpio1_pin_in = 1'b0;
        tick(4);
        rc(8'hA6, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(8'hA7, 8'(k));
            tick(1);
            chk("src_min", {1'b0, drp_src_min_ms}, 8'(15 + 5 * k));
            chk("snk_min", {1'b0, drp_snk_min_ms}, 8'(35 - 5 * k));
        end
    endtask : t_reset_and_gpio

    // Arm a sink transmit, step the advertisement 1.5 A to 3.0 A, count the starts
    task automatic t_sink_tx(input logic [7:0] d, input int exp_n, input logic bist, input logic drop_role);
        int n0;
        n0 = n_tx;
        wr(8'hB0, d);
        // The write is always made as sink; the role may be lost while armed
        role_is_sink = !drop_role;
        rp_adv_1p5a = 1'b1;
        tick(2);
        rp_adv_1p5a = 1'b0;
        rp_adv_3p0a = 1'b1;
        tick(4);
        chk("bist_active", {7'h0, bist_active}, {7'h0, bist});
        chk("pkt_type", {5'h0, tx_packet_type}, {5'h0, d[2:0]});
        tick(60);
        rp_adv_3p0a = 1'b0;
        chk("bist_active", {7'h0, bist_active}, 8'h00);
        chk("tx_count", 8'(n_tx - n0), 8'(exp_n));
    endtask : t_sink_tx

    // Source swap by register with each gate mode, then by the GPIO falling edge
    task automatic t_swap();
        int n0;
        wr(8'hB1, 8'h01);
        chk("gate", {7'h0, sink_gate_en}, 8'h01);
        rc(8'hB1, 8'h00);
        wr(8'hB1, 8'h00);
        wr(8'hB1, 8'h05);
        for (int i = 0; i < 20 && frs_signal_done !== 1'b1; i++) tick(1);
        tick(4);
        chk("gate", {7'h0, sink_gate_en}, 8'h00);
        tick(8);
        chk("gate", {7'h0, sink_gate_en}, 8'h01);
        wr(8'hB1, 8'h00);
        wr(8'hB1, 8'h03);
        tick(60);
        chk("gate", {7'h0, sink_gate_en}, 8'h00);
        n0 = n_sw;
        wr(8'hA5, 8'h0A);
        tick(4);
        gpio2_pin_in = 1'b0;
        tick(10);
        chk("swap_count", 8'(n_sw - n0), 8'h01);
        rc(8'hB3, 8'h02);
        wr(8'hB3, 8'h02);
        frs_request_rx = 1'b1;
        tick(1);
        frs_request_rx = 1'b0;
        tick(1);
        rc(8'hB3, 8'h01);
        wr(8'hA5, 8'h0D);
        chk("pin_out", {7'h0, gpio2_pin_out}, 8'h01);
        vbus_disconnect = 1'b1;
        tick(1);
        vbus_disconnect = 1'b0;
        tick(2);
        chk("pin_out", {7'h0, gpio2_pin_out}, 8'h00);
    endtask : t_swap

    // Watchdog, far beyond the under one thousand cycles the tests need
    initial begin
        #200us;
        n_mismatch++;
        summarize();
    end

    // Main sequence
    initial begin
        {reg_wr, reg_rd, gpio1_input_enable, gpio1_pin_in, gpio2_pin_in, vbus_disconnect} = '0;
        {rp_adv_1p5a, rp_adv_3p0a, frs_request_rx} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        role_is_sink = 1'b1;
        fail_all = 1'b1;
        n_mismatch = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset_and_gpio();
        for (int t = 0; t < 8; t++) t_sink_tx(8'h10 | 8'(t), (t > 4) ? 1 : 2, t == 7, 1'b0);
        t_sink_tx(8'h30, 4, 1'b0, 1'b0);
        t_sink_tx(8'h40, 0, 1'b0, 1'b0);
        t_sink_tx(8'h00, 0, 1'b0, 1'b1);
        role_is_sink = 1'b1;
        t_swap();
        summarize();
    end
endmodule : frs_regs_top_bench
